/* include/ctc_pkg.sv */
package ctc_pkg;
    // ==========================================
    // register map
    localparam logic [7:0] CFG_ADDR = 8'h38;
    localparam logic [7:0] HVTHR_ADDR = 8'h3c;
    localparam logic [7:0] STATUS_ADDR = 8'h40;
    localparam logic [31:0] CFG_RESET = 32'h10410150;
    // bits 17 and 13 are reserved and read as zero
    localparam logic [31:0] CFG_WMASK = 32'hfffddfff;
    localparam logic [22:0] HVTHR_RESET = 23'h000000;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

    // ==========================================
    // timing and chopper constants; blank and slow base lengths in clk cycles
    localparam logic [5:0] BLANK_CLKS_0 = 6'h10;
    localparam logic [5:0] BLANK_CLKS_1 = 6'h18;
    localparam logic [5:0] BLANK_CLKS_2 = 6'h24;
    localparam logic [5:0] BLANK_CLKS_3 = 6'h36;
    localparam logic [9:0] SLOW_BASE_CLKS = 10'h018;
    localparam int DECAY_SHIFT = 5;
    localparam logic [3:0] HYST_PRESC_LAST = 4'hf;
    localparam logic signed [6:0] HYST_BIAS = 7'sh03;
    localparam logic [7:0] FS_POS_45 = 8'h80;
    localparam logic [3:0] OFF_TIME_DISABLE = 4'h0;
    localparam logic [3:0] FAST_TIME_NONE = 4'h0;
    localparam logic [9:0] CNT_LAST = 10'h001;

    // ==========================================
    // types
    typedef struct packed {
        logic [11:0] other;
        logic hvChopSel;
        logic hvFullStepSel;
        logic rsvd17;
        logic [1:0] blankTimeSelect;
        logic chm;
        logic rsvd13;
        logic disFdcc;
        logic decayTimeMsb;
        logic [3:0] hystLowOrSineOffset;
        logic [2:0] hystStartOrDecayLowBits;
        logic [3:0] slowDecayOffTime;
    } ctc_config_t;

    typedef struct packed {
        logic [19:0] zero;
        logic [5:0] hyst;
        logic velHigh;
        logic blanking;
        logic hvChop;
        logic fullStep;
        logic [1:0] state;
    } ctc_status_t;

    typedef enum logic [1:0] {
        CS_OFF = 2'b00,
        CS_ON = 2'b01,
        CS_FAST = 2'b10,
        CS_SLOW = 2'b11
    } ctc_chop_state_t;

    // ==========================================
    // functions
    function automatic logic [5:0] ctc_blank_clks(input logic [1:0] code);
        case (code)
            2'b00: return BLANK_CLKS_0;
            2'b01: return BLANK_CLKS_1;
            2'b10: return BLANK_CLKS_2;
            default: return BLANK_CLKS_3;
        endcase
    endfunction : ctc_blank_clks

    // doubling keeps the chopper frequency at high velocity
    function automatic logic [9:0] ctc_slow_clks(input logic [3:0] offTime, input logic dbl);
        logic [4:0] units;
        units = dbl ? {offTime, 1'b0} : {1'b0, offTime};
        return SLOW_BASE_CLKS + (10'(units) << DECAY_SHIFT);
    endfunction : ctc_slow_clks

    function automatic logic [9:0] ctc_fast_clks(input logic [3:0] fastTime);
        return 10'(fastTime) << DECAY_SHIFT;
    endfunction : ctc_fast_clks

    // code 0..15 stands for -3..12
    function automatic logic signed [6:0] ctc_low_units(input logic [3:0] code);
        return $signed({3'b000, code}) - HYST_BIAS;
    endfunction : ctc_low_units
endpackage : ctc_pkg

/* include/ctc_reg_if.sv */
interface ctc_reg_if;
    import ctc_pkg::*;
    ctc_config_t chopper_configuration;
    logic [22:0] velThr;
    ctc_status_t status;
    modport regs (output chopper_configuration, output velThr, input status);
    modport core (input chopper_configuration, input velThr, output status);
endinterface : ctc_reg_if

/* hdl/ctc_blank_timer.sv */
module ctc_blank_timer
    import ctc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic start,
    input wire logic [1:0] blankSel,
    output logic blanking
);
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;

    // ==========================================
    // blank counter
    // every switching event except entry to the off state restarts the mask
    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = ctc_blank_clks(blankSel);
        end else if (cnt_q != 6'h00) begin
            cnt_d = cnt_q - 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= 6'h00;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

    assign blanking = (cnt_q != 6'h00);

    // ==========================================
    // checks
    AST_BLANK_STARTS: assert property (
        @(posedge clk) disable iff (!reset_n || !ce)
        start |=> blanking)
        else $error("blanking did not start");

    AST_BLANK_16: assert property (
        @(posedge clk) disable iff (!reset_n || !ce)
        (start && blankSel == 2'b00) ##1 (!start)[*8] ##1 (!start)[*8] |=> !blanking)
        else $error("blank time code 0 is not 16 clocks");
endmodule : ctc_blank_timer

/* hdl/ctc_apb_regs.sv */
module ctc_apb_regs
    import ctc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    ctc_reg_if.regs rif
);
    ctc_config_t conf_q;
    ctc_config_t conf_d;
    logic [22:0] high_velocity_threshold_q;
    logic [22:0] high_velocity_threshold_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic err_q;
    logic err_d;
    logic rdy_q;
    logic rdy_d;
    logic done;

    // rdy_q says read data was latched at a live edge for this address
    assign pready = ce && rdy_q && penable;
    assign done = psel && penable && pready;

    // ==========================================
    // decode, write and read data
    always_comb begin
        conf_d = conf_q;
        high_velocity_threshold_d = high_velocity_threshold_q;
        prdata_d = prdata_q;
        err_d = err_q;
        rdy_d = psel && !done;
        if (psel && !done) begin
            err_d = 1'b0;
            case (paddr)
                CFG_ADDR: prdata_d = conf_q;
                HVTHR_ADDR: prdata_d = {9'h000, high_velocity_threshold_q};
                STATUS_ADDR: prdata_d = rif.status;
                default: begin
                    prdata_d = READ_ZERO;
                    err_d = 1'b1;
                end
            endcase
        end
        if (done && pwrite) begin
            case (paddr)
                CFG_ADDR: conf_d = pwdata & CFG_WMASK;
                HVTHR_ADDR: high_velocity_threshold_d = pwdata[22:0];
                default: high_velocity_threshold_d = high_velocity_threshold_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            conf_q <= CFG_RESET;
            high_velocity_threshold_q <= HVTHR_RESET;
            prdata_q <= READ_ZERO;
            err_q <= 1'b0;
            rdy_q <= 1'b0;
        end else if (ce) begin
            conf_q <= conf_d;
            high_velocity_threshold_q <= high_velocity_threshold_d;
            prdata_q <= prdata_d;
            err_q <= err_d;
            rdy_q <= rdy_d;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = err_q && pready;
    assign rif.chopper_configuration = conf_q;
    assign rif.velThr = high_velocity_threshold_q;
endmodule : ctc_apb_regs

/* hdl/ctc_chopper_top.sv */
// Contract
// - full-step select set and velocity above threshold: switch to full step
// - microstep and full-step change only at the 45 degree point
// - full step uses the table value taken at 45 degrees as target
// - blank code 0..3 masks comparator for 16, 24, 36, 54 clocks
// - mode bit: 0 hysteresis chopper, 1 constant off time with fast decay
// - constant off time: negative nominal current ends fast decay early
// - termination-disable bit set: fast decay ignores comparator, runs full time
// - bit 11 is the fast-decay time MSB in constant off time mode
// - hysteresis mode: low value code 0..15 means -3..12 units
// - constant off time: same field is sine offset added to every entry
// - hysteresis start is low value plus 1..8
// - active hysteresis drops one step every 16 clocks
// - fast decay lasts 32 times fast time; zero means slow decay only
// - slow decay lasts 24 plus 32 times off time clocks
// - off time zero disables driver, all bridge switches off
// - high-velocity chopper bit: constant off time with fast time zero
// - high-velocity chopper doubles off time to hold chopper frequency
//
// Chosen here: register access over APB and the address map.
module ctc_chopper_top
    import ctc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [22:0] actualVelocity,
    input wire logic [9:0] microstepPos,
    input wire logic [8:0] sineTableValue,
    input wire logic [8:0] sineAt45Value,
    input wire logic coilAboveThreshold,
    input wire logic coilNegReached,
    output logic bridgeOn,
    output logic bridgeFastDecay,
    output logic bridgeSlowDecay,
    output logic driverEnable,
    output logic [9:0] targetCurrent,
    output logic fullStepActive,
    output logic comparatorBlanked
);
    ctc_reg_if rif ();
    ctc_config_t cfg;

    ctc_chop_state_t state_q;
    ctc_chop_state_t state_d;
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic signed [6:0] hyst_q;
    logic signed [6:0] hyst_d;
    logic [3:0] presc_q;
    logic [3:0] presc_d;
    logic fullStep_q;
    logic fullStep_d;
    logic [9:0] target_q;
    logic [9:0] target_d;
    logic [1:0] aboveSync_q;
    logic [1:0] aboveSync_d;
    logic [1:0] negSync_q;
    logic [1:0] negSync_d;

    logic velHigh;
    logic hvChop;
    logic effChm;
    logic [3:0] fastEff;
    logic offZero;
    logic signed [6:0] lowUnits;
    logic signed [6:0] hystStart;
    logic signed [6:0] adj;
    logic signed [10:0] sum;
    logic [8:0] base;
    logic blanking;
    logic cmpAbove;
    logic cmpNeg;
    logic startBlank;

    // ==========================================
    // register file over apb
    ctc_apb_regs u_regs (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .rif(rif.regs)
    );

    assign cfg = rif.chopper_configuration;

    // ==========================================
    // comparator blanking
    ctc_blank_timer u_blank (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .start(startBlank),
        .blankSel(cfg.blankTimeSelect),
        .blanking(blanking)
    );

    // ==========================================
    // effective mode decode
    assign velHigh = actualVelocity > rif.velThr;
    assign hvChop = cfg.hvChopSel && velHigh;
    assign effChm = cfg.chm || hvChop;
    // the high-velocity chopper (select bit set and velocity high) forces the fast time to zero
    assign fastEff = hvChop ? FAST_TIME_NONE
        : {cfg.decayTimeMsb, cfg.hystStartOrDecayLowBits};
    assign offZero = (cfg.slowDecayOffTime == OFF_TIME_DISABLE);
    assign lowUnits = ctc_low_units(cfg.hystLowOrSineOffset);
    // overflow past 16 is on software, no clamp here
    assign hystStart = lowUnits
        + $signed({4'h0, cfg.hystStartOrDecayLowBits}) + 7'sh01;

    // the comparator pins are asynchronous; only the second stage is read
    assign aboveSync_d = {aboveSync_q[0], coilAboveThreshold};
    assign negSync_d = {negSync_q[0], coilNegReached};
    assign cmpAbove = aboveSync_q[1] && !blanking;
    assign cmpNeg = negSync_q[1] && !blanking;

    // ==========================================
    // chopper phase machine
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (cnt_q != 10'h000) begin
            cnt_d = cnt_q - 10'h001;
        end
        if (offZero) begin
            state_d = CS_OFF;
            cnt_d = 10'h000;
        end else begin
            case (state_q)
                CS_OFF: begin
                    state_d = CS_ON;
                end
                CS_ON: begin
                    if (cmpAbove) begin
                        if (!effChm) begin
                            state_d = CS_FAST;
                        end else if (fastEff == FAST_TIME_NONE) begin
                            state_d = CS_SLOW;
                            cnt_d = ctc_slow_clks(cfg.slowDecayOffTime, hvChop);
                        end else begin
                            state_d = CS_FAST;
                            cnt_d = ctc_fast_clks(fastEff);
                        end
                    end
                end
                CS_FAST: begin
                    if (effChm) begin
                        // early end unless comparator termination is off
                        if (cnt_q <= CNT_LAST
                            || (!cfg.disFdcc && cmpNeg)) begin
                            state_d = CS_SLOW;
                        end
                    end else if (!cmpAbove && !blanking) begin
                        state_d = CS_SLOW;
                    end
                    if (state_d == CS_SLOW) begin
                        cnt_d = ctc_slow_clks(cfg.slowDecayOffTime, hvChop);
                    end
                end
                CS_SLOW: begin
                    if (cnt_q <= CNT_LAST) begin
                        state_d = CS_ON;
                    end
                end
                default: begin
                    state_d = CS_OFF;
                end
            endcase
        end
    end

    assign startBlank = (state_d != state_q) && (state_d != CS_OFF);

    // ==========================================
    // hysteresis ramp
    // the start value is reloaded at every new on phase
    always_comb begin
        presc_d = presc_q + 4'h1;
        hyst_d = hyst_q;
        if (state_d == CS_ON && state_q != CS_ON) begin
            hyst_d = hystStart;
        end else if (presc_q == HYST_PRESC_LAST && hyst_q > lowUnits) begin
            hyst_d = hyst_q - 7'sh01;
        end
    end

    // ==========================================
    // full step switch, only taken at the 45 degree point
    always_comb begin
        fullStep_d = fullStep_q;
        if (microstepPos[7:0] == FS_POS_45) begin
            fullStep_d = cfg.hvFullStepSel && velHigh;
        end
    end

    // ==========================================
    // target current for the comparator
    always_comb begin
        base = fullStep_q ? sineAt45Value : sineTableValue;
        if (effChm) begin
            adj = lowUnits;
        end else if (state_q == CS_FAST) begin
            adj = -hyst_q;
        end else begin
            adj = hyst_q;
        end
        sum = $signed({2'b00, base}) + 11'(adj);
        target_d = sum[10] ? 10'h000 : sum[9:0];
    end

    // ==========================================
    // state registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= CS_OFF;
            cnt_q <= 10'h000;
            hyst_q <= 7'sh00;
            presc_q <= 4'h0;
            fullStep_q <= 1'b0;
            target_q <= 10'h000;
            aboveSync_q <= 2'b00;
            negSync_q <= 2'b00;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hyst_q <= hyst_d;
            presc_q <= presc_d;
            fullStep_q <= fullStep_d;
            target_q <= target_d;
            aboveSync_q <= aboveSync_d;
            negSync_q <= negSync_d;
        end
    end

    // ==========================================
    // outputs and status
    assign bridgeOn = (state_q == CS_ON);
    assign bridgeFastDecay = (state_q == CS_FAST);
    assign bridgeSlowDecay = (state_q == CS_SLOW);
    assign driverEnable = (state_q != CS_OFF);
    assign targetCurrent = target_q;
    assign fullStepActive = fullStep_q;
    assign comparatorBlanked = blanking;

    always_comb begin
        rif.status = '0;
        rif.status.hyst = hyst_q[5:0];
        rif.status.velHigh = velHigh;
        rif.status.blanking = blanking;
        rif.status.hvChop = hvChop;
        rif.status.fullStep = fullStep_q;
        rif.status.state = state_q;
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n || !ce);

    AST_SLOW_DECAY_OFF_TIME_ZERO_OFF: assert property (
        offZero |=> !driverEnable && !bridgeOn)
        else $error("driver not off with off time zero");

    AST_FS_AT_45: assert property (
        $changed(fullStep_q) |-> $past(microstepPos[7:0]) == FS_POS_45)
        else $error("full step changed away from 45 degrees");

    AST_FS_ENTER: assert property (
        (cfg.hvFullStepSel && velHigh && microstepPos[7:0] == FS_POS_45) |=> fullStepActive)
        else $error("full step not entered");

    AST_BLANK_HOLDS_ON: assert property (
        (state_q == CS_ON && blanking && !offZero) |=> state_q == CS_ON)
        else $error("comparator acted during blank time");

    AST_SLOW_LOAD: assert property (
        (state_q != CS_SLOW && state_d == CS_SLOW)
        |=> cnt_q == ctc_slow_clks($past(cfg.slowDecayOffTime), $past(hvChop)))
        else $error("slow decay length wrong");

    AST_SLOW_END: assert property (
        (state_q == CS_SLOW && cnt_q == CNT_LAST && !offZero) |=> state_q == CS_ON)
        else $error("slow decay did not end");

    AST_NO_FAST_ZERO: assert property (
        (state_q == CS_ON && effChm && fastEff == FAST_TIME_NONE) |=> state_q != CS_FAST)
        else $error("fast decay with fast time zero");

    AST_FAST_FULL: assert property (
        (state_q == CS_FAST && effChm && cfg.disFdcc && cnt_q > CNT_LAST && !offZero)
        |=> state_q == CS_FAST)
        else $error("fast decay cut short with termination off");

    AST_HYST_PACE: assert property (
        // the reload at a new on phase may drop the value off the grid
        (state_q != CS_OFF && $past(state_q) == state_q && hyst_q < $past(hyst_q))
        |-> $past(presc_q) == HYST_PRESC_LAST)
        else $error("hysteresis stepped off the 16 clock grid");
endmodule : ctc_chopper_top

/* dv/ctc_bridge_model.sv */
// ==========================================
// bridge and comparator stand-in
// current rises while the bridge is on and crosses the target after onClks;
// the negative comparator fires negClks into fast decay (0: never)
module ctc_bridge_model #(
    parameter int ON_CLKS = 60
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic bridgeOn,
    input wire logic bridgeFastDecay,
    input wire logic [7:0] negClks,
    output logic coilAboveThreshold,
    output logic coilNegReached
);
    timeunit 1ns;
    timeprecision 1ps;
    int onCnt = 0;
    int fastCnt = 0;

    // phase age counters, cleared whenever the phase is left
    always @(posedge clk) begin
        onCnt <= (!reset_n || !bridgeOn) ? 0 : onCnt + 1;
        fastCnt <= (!reset_n || !bridgeFastDecay) ? 0 : fastCnt + 1;
    end

    // onClks above the longest blank so the crossing is never masked
    assign coilAboveThreshold = bridgeOn && onCnt >= ON_CLKS;
    assign coilNegReached = bridgeFastDecay && negClks != 8'h00 && fastCnt >= int'(negClks);
endmodule : ctc_bridge_model

/* dv/tb_top.sv */
module tb_top
    import ctc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // stimulus and observed ports
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [22:0] actualVelocity = 23'h000000;
    logic [9:0] microstepPos = 10'h000;
    logic [8:0] sineTableValue = 9'h020;
    logic [8:0] sineAt45Value = 9'h0b4;
    logic [7:0] negClks = 8'h00;
    logic pready, pslverr, coilAbove, coilNeg, bridgeOn, bridgeFastDecay, bridgeSlowDecay;
    logic driverEnable, fullStepActive, comparatorBlanked;
    logic [31:0] prdata;
    logic [9:0] targetCurrent;
    int failures = 0;
    int checks_done = 0;

    always #12.5 clk = ~clk;

    ctc_chopper_top DUT (.clk(clk), .reset_n(reset_n), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .actualVelocity(actualVelocity), .microstepPos(microstepPos),
        .sineTableValue(sineTableValue), .sineAt45Value(sineAt45Value),
        .coilAboveThreshold(coilAbove), .coilNegReached(coilNeg), .bridgeOn(bridgeOn),
        .bridgeFastDecay(bridgeFastDecay), .bridgeSlowDecay(bridgeSlowDecay),
        .driverEnable(driverEnable), .targetCurrent(targetCurrent),
        .fullStepActive(fullStepActive), .comparatorBlanked(comparatorBlanked));

    ctc_bridge_model bridge (.clk(clk), .reset_n(reset_n), .bridgeOn(bridgeOn),
        .bridgeFastDecay(bridgeFastDecay), .negClks(negClks),
        .coilAboveThreshold(coilAbove), .coilNegReached(coilNeg));

    // ==========================================
    // shared helpers
    task automatic finish_test();
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            failures++;
            finish_test();
        end
    endtask : apb

    function automatic logic [31:0] mk(input logic [1:0] bsel, input logic chm,
        input logic dis, input logic [3:0] fast, input logic [3:0] low,
        input logic [3:0] offt, input logic [1:0] vh);
        return {12'h000, vh, 1'b0, bsel, chm, 1'b0, dis, fast[3], low, fast[2:0], offt};
    endfunction : mk

    // stop first so every run starts from the off state
    task automatic start(input logic [31:0] w);
        logic [31:0] q;
        logic e;
        apb(1'b1, CFG_ADDR, 32'h00000000, q, e);
        apb(1'b1, CFG_ADDR, w, q, e);
    endtask : start

    function automatic logic pick(input int s);
        case (s)
            0: return comparatorBlanked;
            1: return bridgeOn;
            2: return bridgeFastDecay;
            3: return bridgeSlowDecay;
            default: return fullStepActive;
        endcase
    endfunction : pick

    task automatic wait_hi(input int s);
        int k;
        k = 0;
        while (pick(s) !== 1'b1) begin
            @(posedge clk);
            #1;
            k++;
            if (k > 3000) begin
                failures++;
                finish_test();
            end
        end
    endtask : wait_hi

    // cycles a phase stays high, counted from now if already high, else from its next rise
    task automatic span(input int s, output int n);
        wait_hi(s);
        n = 0;
        while (pick(s) === 1'b1 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : span

    // ==========================================
    // scenarios
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        apb(1'b0, CFG_ADDR, 32'h00000000, q, e);
        chk("cfg reset", q, CFG_RESET);
        chk("driver off", {31'h0, driverEnable}, 32'h0);
        apb(1'b1, CFG_ADDR, 32'hfffffff0, q, e);
        apb(1'b1, 8'h10, 32'h0000000f, q, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        apb(1'b0, CFG_ADDR, 32'h00000000, q, e);
        chk("cfg readback", q, 32'hfffddff0);
        apb(1'b1, HVTHR_ADDR, 32'hffffffff, q, e);
        apb(1'b0, HVTHR_ADDR, 32'h00000000, q, e);
        chk("high_velocity_threshold readback", q, 32'h007fffff);
    endtask : t_regs

    task automatic t_blank();
        int blk[4] = '{16, 24, 36, 54};
        int n;
        // all four codes on purpose; off time 2 is legal with any code
        for (int c = 0; c < 4; c++) begin
            start(mk(2'(c), 1'b1, 1'b1, 4'h1, 4'h3, 4'h2, 2'b00));
            span(0, n);
            chk("blank clks", n, blk[c]);
        end
    endtask : t_blank

    task automatic t_cot();
        logic [31:0] q;
        logic e;
        int n;
        start(mk(2'd1, 1'b1, 1'b1, 4'h1, 4'h3, 4'h2, 2'b00));
        wait_hi(2);
        chk("blank at fast", {31'h0, comparatorBlanked}, 32'h1);
        span(2, n);
        chk("fast tfd1", n, 32);
        span(3, n);
        chk("slow toff2", n, 88);
        start(mk(2'd1, 1'b1, 1'b1, 4'h8, 4'h3, 4'h2, 2'b00));
        span(2, n);
        chk("fast tfd8", n, 256);
        start(mk(2'd1, 1'b1, 1'b1, 4'h0, 4'h3, 4'h2, 2'b00));
        span(1, n);
        chk("no fast", {30'h0, bridgeFastDecay, bridgeSlowDecay}, 32'h1);
        // slow phase is 88 clocks, far longer than the read
        apb(1'b0, STATUS_ADDR, 32'h00000000, q, e);
        chk("status slow", q & 32'h00000003, 32'h3);
    endtask : t_cot

    task automatic t_early();
        int n;
        negClks <= 8'd40;
        start(mk(2'd1, 1'b1, 1'b0, 4'h4, 4'h3, 4'h2, 2'b00));
        span(2, n);
        chk("fast cut", {31'h0, n >= 40 && n < 128}, 32'h1);
        start(mk(2'd1, 1'b1, 1'b1, 4'h4, 4'h3, 4'h2, 2'b00));
        span(2, n);
        chk("fast full", n, 128);
        negClks <= 8'd0;
    endtask : t_early

    // low code 7 is +4, start code 0 adds 1; ramp settles at +4 within 16 clocks
    task automatic t_hyst();
        start(mk(2'd1, 1'b0, 1'b0, 4'h0, 4'h7, 4'h2, 2'b00));
        wait_hi(1);
        repeat (40) @(posedge clk);
        #1;
        chk("hyst on target", {22'h0, targetCurrent}, 32'h24);
        wait_hi(2);
        repeat (3) @(posedge clk);
        #1;
        chk("hyst fast target", {22'h0, targetCurrent}, 32'h1c);
    endtask : t_hyst

    task automatic t_hv();
        logic [31:0] q;
        logic e;
        int n;
        @(posedge clk);
        actualVelocity <= 23'd1000;
        apb(1'b1, HVTHR_ADDR, 32'd100, q, e);
        // start plus low kept small
        start(mk(2'd1, 1'b0, 1'b0, 4'h0, 4'h3, 4'h2, 2'b10));
        span(1, n);
        chk("hv no fast", {30'h0, bridgeFastDecay, bridgeSlowDecay}, 32'h1);
        span(3, n);
        chk("hv slow", n, 152);
    endtask : t_hv

    task automatic t_fs();
        @(posedge clk);
        microstepPos <= 10'h010;
        start(mk(2'd1, 1'b1, 1'b1, 4'h1, 4'h7, 4'h2, 2'b01));
        repeat (40) @(posedge clk);
        #1;
        chk("fs held off", {31'h0, fullStepActive}, 32'h0);
        chk("offset target", {22'h0, targetCurrent}, 32'h24);
        @(posedge clk);
        microstepPos <= 10'h180;
        wait_hi(4);
        repeat (3) @(posedge clk);
        #1;
        chk("fs target", {22'h0, targetCurrent}, 32'hb8);
    endtask : t_fs

    // ==========================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_blank();
        t_cot();
        t_early();
        t_hyst();
        t_hv();
        t_fs();
        finish_test();
    end
endmodule : tb_top
